// *** pcl_cfg.svh ***
// register offsets, control field positions and reset values for the colour lookup
`ifndef PCL_CFG_SVH
`define PCL_CFG_SVH
`define PCL_PAL_LAST 6'h1F
`define PCL_CTRL_ADDR 6'h20
`define PCL_STAT_ADDR 6'h21
`define PCL_HIRES_BIT 15
`define PCL_COUNT_LSB 12
`define PCL_COUNT_MSB 14
`define PCL_HOLD_BIT 11
`define PCL_DUAL_BIT 10
`define PCL_CTRL_RESET 16'h0000
`define PCL_COLOR_RESET 12'h000
`define PCL_HALF_COUNT 3'h6
`define PCL_HOLD_COUNT_LO 3'h5
`define PCL_FIFO_DEPTH 32
`define PCL_FIFO_LVL_W 6
`define PCL_PLANES 6
`define PCL_ENTRIES 32
`endif

// *** pcl_pkg.sv ***
// types shared by the playfield colour lookup
package pcl_pkg;
    typedef struct packed {
        logic [3:0] red;
        logic [3:0] green;
        logic [3:0] blue;
    } pcl_color_type;
    typedef struct packed {
        logic hires;
        logic [2:0] active_plane_count;
        logic hold_modify_select;
        logic two_playfield_select;
    } pcl_ctrl_type;
    typedef enum logic [1:0] {
        PCL_HM_DIRECT = 2'h0,
        PCL_HM_BLUE = 2'h1,
        PCL_HM_RED = 2'h2,
        PCL_HM_GREEN = 2'h3
    } pcl_hm_type;
endpackage

// *** pcl_top.sv ***
// playfield colour lookup: palette registers, pixel fifo and colour formation
`timescale 1ns/10ps
`include "pcl_cfg.svh"

module pcl_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 32,
    parameter int LVL_W = 6
) (
    input wire logic clock_i, // pixel clock
    input wire logic rst_i, // async reset, high
    input wire logic in_valid_i, // write request
    input wire logic [WIDTH-1:0] in_data_i, // write word
    output logic in_ready_o, // room left
    output logic out_valid_o, // word available
    output logic [WIDTH-1:0] out_data_o, // head word
    input wire logic out_ready_i, // head consumed
    output logic [LVL_W-1:0] level_o // words held
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [LVL_W-1:0] cnt_ff, nxt_cnt;
    logic rdy_ff, nxt_rdy, push, pop;

    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem[rp_ff];
    assign in_ready_o = rdy_ff;
    assign level_o = cnt_ff;

    always_comb
    begin
        push = in_valid_i & rdy_ff;
        pop = out_ready_i & out_valid_o;
        nxt_wp = push ? AW'(wp_ff + 1'b1) : wp_ff;
        nxt_rp = pop ? AW'(rp_ff + 1'b1) : rp_ff;
        nxt_cnt = LVL_W'(cnt_ff + LVL_W'(push) - LVL_W'(pop));
        // ready is registered so the source sees it straight from a flop
        nxt_rdy = (nxt_cnt != LVL_W'(DEPTH));
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b1;
        end
        else
        begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_rdy;
        end
    end

    // storage needs no reset; the pointers guard it
    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem[wp_ff] <= in_data_i;
        end
    end
endmodule

// Overview of operation
// - thirty-two palette entries, each 4-bit red, green and blue
// - palette entries are write-only; reading one returns zero
// - palette word: red 11-8, green 7-4, blue 3-0; upper nibble written zero
// - low-res single playfield: planes 5..1 index entries 0 to 31
// - entry zero is the background colour
// - low-res dual: planes 5,3,1 select entries 0 to 7
// - low-res dual: planes 6,4,2 select 8 to 15, zero is transparent
// - high-res single: planes 4..1 select entries 0 to 15 only
// - high-res dual: planes 3,1 select 1 to 3, zero transparent
// - high-res dual: planes 4,2 select 9 to 11, zero transparent
// - hold-modify: planes 4..1 address entries 0 to 15 only
// - half-bright needs low-res, six planes, hold-modify and dual cleared
// - half-bright: plane six halves the colour picked by planes 1..5
// - hold-modify needs bit 11, not dual, low-res, five or six planes
// - plane count field gives zero to six planes, zero is background
// - control bit 15 selects high-resolution mapping
module pcl_top (
    input wire logic clock_i, // 10 MHz pixel clock
    input wire logic rst_i, // async reset, high
    input wire logic [5:0] addr_i, // register address
    input wire logic [15:0] wdata_i, // register write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [15:0] rdata_o, // read data, cycle after strobe
    input wire logic pix_valid_i, // plane bits valid
    input wire logic [5:0] pix_planes_i, // planes 6..1, plane 1 in bit 0
    output logic pix_ready_o, // fifo accepts plane bits
    output logic rgb_valid_o, // colour valid
    output pcl_pkg::pcl_color_type rgb_o, // 12-bit colour
    input wire logic rgb_ready_i // encoder takes colour
);
    pcl_pkg::pcl_color_type pal_ff [`PCL_ENTRIES];
    pcl_pkg::pcl_color_type nxt_pal [`PCL_ENTRIES];
    pcl_pkg::pcl_ctrl_type ctrl_ff, nxt_ctrl;
    pcl_pkg::pcl_color_type rgb_ff, nxt_rgb, held_ff, nxt_held, col;
    pcl_pkg::pcl_hm_type hm;
    logic [15:0] rdata_ff, nxt_rdata;
    logic vld_ff, nxt_vld, take, f_vld, half, hold_modify_enable, half_brightness_mode;
    logic [5:0] f_q, pl;
    logic [4:0] idx;
    logic [2:0] pf1, pf2;
    logic [`PCL_FIFO_LVL_W-1:0] level;

    pcl_fifo #(
        .WIDTH(`PCL_PLANES),
        .DEPTH(`PCL_FIFO_DEPTH),
        .LVL_W(`PCL_FIFO_LVL_W)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(pix_valid_i),
        .in_data_i(pix_planes_i),
        .in_ready_o(pix_ready_o),
        .out_valid_o(f_vld),
        .out_data_o(f_q),
        .out_ready_i(take),
        .level_o(level)
    );

    // register file
    always_comb
    begin
        nxt_pal = pal_ff;
        nxt_ctrl = ctrl_ff;
        nxt_rdata = 16'h0000;
        if (wr_i && addr_i <= `PCL_PAL_LAST)
        begin
            nxt_pal[addr_i[4:0]] = wdata_i[11:0];
        end
        if (wr_i && addr_i == `PCL_CTRL_ADDR)
        begin
            nxt_ctrl.hires = wdata_i[`PCL_HIRES_BIT];
            nxt_ctrl.active_plane_count = wdata_i[`PCL_COUNT_MSB:`PCL_COUNT_LSB];
            nxt_ctrl.hold_modify_select = wdata_i[`PCL_HOLD_BIT];
            nxt_ctrl.two_playfield_select = wdata_i[`PCL_DUAL_BIT];
        end
        if (rd_i)
        begin
            // palette addresses fall through to zero: no colour readback
            case (addr_i)
                `PCL_CTRL_ADDR: nxt_rdata = {ctrl_ff, 10'h000};
                `PCL_STAT_ADDR: nxt_rdata = {9'h000, vld_ff, level};
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < `PCL_ENTRIES; i++)
            begin
                pal_ff[i] <= `PCL_COLOR_RESET;
            end
            ctrl_ff <= pcl_pkg::pcl_ctrl_type'(6'(`PCL_CTRL_RESET >> 10));
            rdata_ff <= 16'h0000;
        end
        else
        begin
            pal_ff <= nxt_pal;
            ctrl_ff <= nxt_ctrl;
            rdata_ff <= nxt_rdata;
        end
    end
    assign rdata_o = rdata_ff;

    // colour formation
    always_comb
    begin
        pl = 6'h00;
        for (int i = 0; i < `PCL_PLANES; i++)
        begin
            // planes beyond the count read as zero; count zero shows background
            pl[i] = f_q[i] & (i < int'(ctrl_ff.active_plane_count));
        end
        hold_modify_enable = !ctrl_ff.hires && !ctrl_ff.two_playfield_select
            && ctrl_ff.hold_modify_select
            && (ctrl_ff.active_plane_count == `PCL_HOLD_COUNT_LO
            || ctrl_ff.active_plane_count == `PCL_HALF_COUNT);
        half_brightness_mode = !ctrl_ff.hires && !ctrl_ff.two_playfield_select
            && !ctrl_ff.hold_modify_select
            && ctrl_ff.active_plane_count == `PCL_HALF_COUNT;
        pf1 = 3'h0;
        pf2 = 3'h0;
        half = 1'b0;
        if (ctrl_ff.two_playfield_select)
        begin
            if (ctrl_ff.hires)
            begin
                pf1 = {1'b0, pl[2], pl[0]};
                pf2 = {1'b0, pl[3], pl[1]};
            end
            else
            begin
                pf1 = {pl[4], pl[2], pl[0]};
                pf2 = {pl[5], pl[3], pl[1]};
            end
            // playfield one sits in front; a zero code lets the other show
            if (pf1 != 3'h0)
                idx = {2'h0, pf1};
            else if (pf2 != 3'h0)
                idx = {2'h1, pf2};
            else
                idx = 5'h00;
        end
        else if (ctrl_ff.hires || hold_modify_enable)
        begin
            idx = {1'b0, pl[3:0]};
        end
        else
        begin
            idx = pl[4:0];
            half = half_brightness_mode & pl[5];
        end
        col = pal_ff[idx];
        if (half)
        begin
            col = {1'b0, col.red[3:1], 1'b0, col.green[3:1], 1'b0, col.blue[3:1]};
        end
        hm = pcl_pkg::pcl_hm_type'(pl[5:4]);
        if (hold_modify_enable)
        begin
            case (hm)
                pcl_pkg::PCL_HM_DIRECT: col = pal_ff[idx];
                pcl_pkg::PCL_HM_BLUE: col = {held_ff.red, held_ff.green, pl[3:0]};
                pcl_pkg::PCL_HM_RED: col = {pl[3:0], held_ff.green, held_ff.blue};
                pcl_pkg::PCL_HM_GREEN: col = {held_ff.red, pl[3:0], held_ff.blue};
                default: col = pal_ff[idx];
            endcase
        end
        take = f_vld && (!vld_ff || rgb_ready_i);
        nxt_rgb = take ? col : rgb_ff;
        // held colour follows the last issued pixel, so stalls do not disturb it
        nxt_held = take ? col : held_ff;
        nxt_vld = take || (vld_ff && !rgb_ready_i);
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rgb_ff <= `PCL_COLOR_RESET;
            held_ff <= `PCL_COLOR_RESET;
            vld_ff <= 1'b0;
        end
        else
        begin
            rgb_ff <= nxt_rgb;
            held_ff <= nxt_held;
            vld_ff <= nxt_vld;
        end
    end
    assign rgb_o = rgb_ff;
    assign rgb_valid_o = vld_ff;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    pal_read_zero_a: assert property (
        rd_i && addr_i <= `PCL_PAL_LAST |=> rdata_o == 16'h0000)
        else $error("palette read returned data");
    pal_store_a: assert property (
        wr_i && addr_i == 6'h03 |=> pal_ff[3] == $past(wdata_i[11:0]))
        else $error("palette word not stored from bits 11 to 0");
    bg_entry_a: assert property (
        take && ctrl_ff.active_plane_count == 3'h0 |=> rgb_o == $past(pal_ff[0]))
        else $error("no planes did not give entry zero");
    lores_index_a: assert property (
        take && ctrl_ff == 6'h14 |=> rgb_o == $past(pal_ff[f_q[4:0]]))
        else $error("low-res index from planes five to one wrong");
    dual_trans_a: assert property (
        take && ctrl_ff.two_playfield_select && f_q == 6'h00
        |=> rgb_o == $past(pal_ff[0]) && rgb_valid_o)
        else $error("both playfields clear did not show background");
    half_bright_a: assert property (
        take && half_brightness_mode && f_q[5]
        |=> rgb_o.red == {1'b0, $past(pal_ff[f_q[4:0]].red[3:1])})
        else $error("half-brightness not applied");
    hires_low_a: assert property (
        take && ctrl_ff.hires && !ctrl_ff.two_playfield_select
        |=> rgb_o == $past(pal_ff[{1'b0, pl[3:0]}]))
        else $error("high-res single index wrong");
    hold_blue_a: assert property (
        take && hold_modify_enable && pl[5:4] == 2'h1
        |=> rgb_o.blue == $past(pl[3:0]) && rgb_o.red == $past(held_ff.red))
        else $error("hold-modify blue replace wrong");
endmodule

// *** pcl_sink.sv ***
// colour sink standing in for the video encoder that takes the pixel stream
`timescale 1ns/10ps
module pcl_sink (
    input wire logic clock_i, // pixel clock
    input wire logic rst_i, // async reset, high
    input wire logic stall_i, // hold ready low
    input wire logic slow_i, // ready every other cycle
    input wire logic rgb_valid_i, // colour offered
    input wire pcl_pkg::pcl_color_type rgb_i, // offered colour
    output logic rgb_ready_o // colour taken at this edge
);
    pcl_pkg::pcl_color_type seen[$];
    always @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rgb_ready_o <= 1'h0;
            seen.delete();
        end
        else
        begin
            // the colour is kept whole, red nibble on top
            if (rgb_valid_i && rgb_ready_o)
                seen.push_back(rgb_i);
            rgb_ready_o <= !stall_i && !(slow_i && rgb_ready_o);
        end
    end
endmodule

// *** test_playfield_color_lookup.sv ***
// self-checking bench for the playfield colour lookup
`timescale 1ns/10ps
module test_playfield_color_lookup;
    logic clock_i = 1'h0;
    logic rst_i = 1'h1;
    logic [5:0] addr_i = 6'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic [15:0] rdata_o;
    logic pix_valid_i = 1'h0;
    logic [5:0] pix_planes_i = 6'h00;
    logic pix_ready_o;
    logic rgb_valid_o;
    pcl_pkg::pcl_color_type rgb_o;
    logic rgb_ready;
    logic stall = 1'h0;
    logic slow = 1'h1;
    logic [15:0] d;
    pcl_pkg::pcl_color_type c;
    pcl_pkg::pcl_color_type e;
    int n_mismatch = 0;
    int tests_run = 0;
    // {control, planes, half flag and entry}
    logic [31:0] rows [23] = '{32'h5000_1F1F, 32'h5000_1515, 32'h5000_0000, 32'h5000_2000,
        32'h0000_3F00, 32'h6400_1507, 32'h6400_2A0F, 32'h6400_0209, 32'h6400_0000,
        32'h6400_0301, 32'h6400_2503, 32'hC000_0F0F, 32'hE000_3F0F, 32'hC400_0101,
        32'hC400_0209, 32'hC400_0A0B, 32'hC400_0000, 32'hE800_2505, 32'h6800_0505,
        32'h6000_2585, 32'h6000_0505, 32'h7000_2505, 32'h5800_0505};

    always #50 clock_i = ~clock_i;

    pcl_top i_pcl_top (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pix_valid_i(pix_valid_i),
        .pix_planes_i(pix_planes_i), .pix_ready_o(pix_ready_o), .rgb_valid_o(rgb_valid_o),
        .rgb_o(rgb_o), .rgb_ready_i(rgb_ready));
    pcl_sink i_pcl_sink (.clock_i(clock_i), .rst_i(rst_i), .stall_i(stall), .slow_i(slow),
        .rgb_valid_i(rgb_valid_o), .rgb_i(rgb_o), .rgb_ready_o(rgb_ready));

    task automatic results;
        $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // distinct colour per entry; half flag gives the dimmed version
    function automatic pcl_pkg::pcl_color_type col(input logic [4:0] k, input logic h);
        pcl_pkg::pcl_color_type v;
        v = {k[3:0], k[4], 3'h5, ~k[3:0]};
        if (h)
            v = {1'h0, v.red[3:1], 1'h0, v.green[3:1], 1'h0, v.blue[3:1]};
        return v;
    endfunction

    // one idle edge after each strobe keeps drivers from double assignment
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'h1;
        @(posedge clock_i);
        wr_i <= 1'h0;
        @(posedge clock_i);
    endtask

    task automatic rd(input logic [5:0] a, output logic [15:0] v);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge clock_i);
        rd_i <= 1'h0;
        @(negedge clock_i);
        v = rdata_o;
        @(posedge clock_i);
    endtask

    task automatic push(input logic [5:0] p);
        int n = 0;
        pix_valid_i <= 1'h1;
        pix_planes_i <= p;
        do
        begin
            @(negedge clock_i);
            n++;
        end
        while (pix_ready_o !== 1'h1 && n < 200);
        if (n >= 200)
        begin
            chk(16'h0000, 16'h0001, "pixel not accepted");
            results();
        end
        @(posedge clock_i);
    endtask

    task automatic take(output pcl_pkg::pcl_color_type v);
        int n = 0;
        while (i_pcl_sink.seen.size() == 0 && n < 500)
        begin
            @(negedge clock_i);
            n++;
        end
        if (n >= 500)
        begin
            chk(16'h0000, 16'h0001, "no colour");
            results();
        end
        v = i_pcl_sink.seen.pop_front();
    endtask

    initial
    begin
        repeat (16) @(posedge clock_i);
        @(negedge clock_i);
        chk({14'h0000, rgb_valid_o, pix_ready_o}, 16'h0001, "reset flags");
        chk(rdata_o, 16'h0000, "reset read data");
        chk({4'h0, rgb_o}, 16'h0000, "reset colour");
        $display("reset test done");
        @(posedge clock_i);
        rst_i <= 1'h0;
        @(posedge clock_i);
        // upper nibble kept zero, as software must write it
        for (int i = 0; i < 32; i++)
            wr(6'(i), {4'h0, col(5'(i), 1'h0)});
        wr(6'h20, 16'h6800);
        rd(6'h20, d);
        chk(d, 16'h6800, "control readback");
        rd(6'h05, d);
        chk(d, 16'h0000, "palette read");
        rd(6'h3F, d);
        chk(d, 16'h0000, "unmapped read");
        $display("register test done");
        for (int r = 0; r < 23; r++)
        begin
            wr(6'h20, rows[r][31:16]);
            push(rows[r][13:8]);
            pix_valid_i <= 1'h0;
            take(c);
            chk({4'h0, c}, {4'h0, col(rows[r][4:0], rows[r][7])}, "row colour");
            @(posedge clock_i);
        end
        $display("mapping test done");
        slow <= 1'h0;
        wr(6'h20, 16'h6800);
        push(6'h05);
        push(6'h1F);
        push(6'h3A);
        push(6'h23);
        pix_valid_i <= 1'h0;
        e = col(5'h05, 1'h0);
        take(c);
        chk({4'h0, c}, {4'h0, e}, "hold lookup");
        e.blue = 4'hF;
        take(c);
        chk({4'h0, c}, {4'h0, e}, "hold blue");
        e.green = 4'hA;
        take(c);
        chk({4'h0, c}, {4'h0, e}, "hold green");
        e.red = 4'h3;
        take(c);
        chk({4'h0, c}, {4'h0, e}, "hold red");
        $display("hold test done");
        @(posedge clock_i);
        stall <= 1'h1;
        wr(6'h20, 16'h5000);
        // one word sits in the output stage, thirty-two in the buffer
        for (int k = 0; k < 33; k++)
            push(6'(k % 32));
        pix_valid_i <= 1'h0;
        @(negedge clock_i);
        chk({14'h0000, rgb_valid_o, pix_ready_o}, 16'h0002, "buffer full");
        rd(6'h21, d);
        chk(d, 16'h0060, "status full");
        @(posedge clock_i);
        stall <= 1'h0;
        for (int k = 0; k < 33; k++)
        begin
            take(c);
            chk({4'h0, c}, {4'h0, col(5'(k % 32), 1'h0)}, "drained colour");
        end
        @(negedge clock_i);
        chk({15'h0000, pix_ready_o}, 16'h0001, "buffer empty");
        $display("buffer test done");
        results();
    end
endmodule
